// File: rtl/acfc_pkg.sv
// Constants, types and carriers for the audio clock and format registers.
// Assumes one clock domain shared by the register port and clock detector.
`default_nettype none
package acfc_pkg;

  // Register offsets on the serial control register port
  localparam logic [7:0] ADDR_CLOCK_SETUP = 8'h00;
  localparam logic [7:0] ADDR_IDENT = 8'h01;
  localparam logic [7:0] ADDR_FAULT = 8'h02;
  localparam logic [7:0] ADDR_SYSOPT = 8'h03;
  localparam logic [7:0] ADDR_FORMAT = 8'h04;

  // Clock setup field positions
  localparam int CLK_RATE_LSB = 5;
  localparam int CLK_MCLK_LSB = 2;
  localparam int CLK_SCLK48_BIT = 1;
  localparam int CLK_VALID_BIT = 0;

  // System option field positions
  localparam int SYS_DCBLK_BIT = 7;
  localparam int SYS_HARDUNM_BIT = 5;
  localparam int SYS_AUTODIS_BIT = 3;
  localparam int SYS_SSDIS_BIT = 2;
  localparam int SYS_DEEMPH_LSB = 0;
  localparam logic [7:0] SYS_WR_MASK = 8'haf;

  // Fault flag field positions
  localparam int FLT_SLIP_BIT = 3;
  localparam int FLT_LRCLK_BIT = 4;
  localparam int FLT_SCLK_BIT = 5;
  localparam int FLT_PLL_BIT = 6;
  localparam int FLT_COUNT = 4;

  // Reset values
  localparam logic [7:0] RST_CLOCK_SETUP = 8'h6c;
  localparam logic [7:0] RST_SYSOPT = 8'ha0;
  localparam logic [7:0] RST_FORMAT = 8'h05;

  // Clock multiples of the sample rate
  localparam logic [9:0] MCLK_X64 = 10'h040;
  localparam logic [9:0] MCLK_X128 = 10'h080;
  localparam logic [9:0] MCLK_X192 = 10'h0c0;
  localparam logic [9:0] MCLK_X256 = 10'h100;
  localparam logic [9:0] MCLK_X384 = 10'h180;
  localparam logic [9:0] MCLK_X512 = 10'h200;
  localparam logic [6:0] SCLK_X32 = 7'h20;
  localparam logic [6:0] SCLK_X48 = 7'h30;
  localparam logic [6:0] SCLK_X64 = 7'h40;
  localparam logic [2:0] RATE_176K4 = 3'h6;

  // Word lengths
  localparam logic [4:0] WLEN_16 = 5'h10;
  localparam logic [4:0] WLEN_18 = 5'h12;
  localparam logic [4:0] WLEN_20 = 5'h14;
  localparam logic [4:0] WLEN_24 = 5'h18;

  typedef enum logic [1:0] {
    JUST_RIGHT, JUST_I2S, JUST_LEFT
  } acfc_just_e;

  typedef enum logic [1:0] {
    DEEMPH_NONE, DEEMPH_RSVD, DEEMPH_44K1, DEEMPH_48K
  } acfc_deemph_e;

  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acfc_req_s;

  // Clock fault events from the clock detector
  typedef struct packed {
    logic pll_lock;
    logic sclk;
    logic lrclk;
    logic slip;
  } acfc_err_s;

  // Decoded configuration for the audio processing core
  typedef struct packed {
    logic [2:0] rate_code;
    logic [9:0] mclk_mult;
    logic mclk_rsvd;
    logic [6:0] sclk_mult;
    logic clk_valid;
    logic dc_block_en;
    logic hard_unmute;
    logic autodetect_en;
    logic soft_start_en;
    acfc_deemph_e deemph;
    acfc_just_e just;
    logic [4:0] word_len;
    logic fmt_valid;
    logic combo_bad;
  } acfc_cfg_s;

endpackage
`default_nettype wire

// File: rtl/acfc_regs.sv
// Clock and serial audio format control registers with status read-back.
// Assumes a register port and a clock detector on the same clock as CLK;
// the detector reports the found rate and ratio and one-cycle fault events.
//
// How it works
// - Master ratio code 011 is 256x, default
// - 101 is 384x, 110 is 512x, 111 reserved
// - Bit 1 picks 48x bit clock, else format
// - Bit 0 marks manual clock settings valid
// - Identification reads fixed 7-bit code, bit7 zero
// - Fault flags sticky, software clears with zeros
// - Fault bits 6 to 3, zero when clean
// - Option bit 7 enables dc-blocking filter
// - Option bit 5 picks hard or soft unmute
// - Option bit 3 low enables clock autodetect
// - Option bit 2 low enables soft start
// - Option bits 1:0 select de-emphasis filter
// - Codes 0-5 right-justified and I2S words
// - Codes 6-8 left-justified, 01010 right 18-bit
// - Autodetect reports found rate and ratio
// - Bits 7:5 carry the sample rate code
`timescale 1ns/1ps
`default_nettype none
module acfc_regs #(
  parameter logic [6:0] ID_CODE = 7'h11 // Arbitrary identification value
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire acfc_pkg::acfc_req_s REG_REQ,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // Clock detector
  input wire logic [2:0] DET_RATE,
  input wire logic [2:0] DET_MCLK,
  input wire acfc_pkg::acfc_err_s DET_ERR,
  // Decoded configuration
  output acfc_pkg::acfc_cfg_s CFG_OUT
);
  import acfc_pkg::*;

  typedef struct packed {
    logic [7:0] clock_setup;
    logic [7:0] sysopt;
    logic [7:0] format;
    logic [7:0] rdata;
    logic rvalid;
    acfc_cfg_s cfg;
  } acfc_state_s;

  typedef struct packed {
    acfc_just_e just;
    logic [4:0] word_len;
    logic sclk32;
    logic valid;
  } acfc_fmt_s;

  acfc_state_s st_reg;
  acfc_state_s st_next;
  logic [FLT_COUNT-1:0] flt_flags;
  logic [FLT_COUNT-1:0] flt_set;
  logic flt_clr_we;
  logic [FLT_COUNT-1:0] flt_keep;
  logic [7:0] fault_view;
  logic [7:0] clock_view;
  logic auto_mode;

  // Master clock multiple for a ratio code, zero when reserved
  function automatic logic [9:0] mclk_mult_of(input logic [2:0] code);
    logic [9:0] m;
    m = '0;
    case (code)
      3'h0: m = MCLK_X64;
      3'h1: m = MCLK_X128;
      3'h2: m = MCLK_X192;
      3'h3: m = MCLK_X256;
      3'h5: m = MCLK_X384;
      3'h6: m = MCLK_X512;
      default: m = '0;
    endcase
    return m;
  endfunction

  // Serial format decode; unlisted codes are reserved
  function automatic acfc_fmt_s fmt_of(input logic [7:0] code);
    acfc_fmt_s f;
    f.just = JUST_I2S;
    f.word_len = WLEN_24;
    f.sclk32 = 1'b0;
    f.valid = 1'b1;
    case (code)
      8'h00: begin
        f.just = JUST_RIGHT;
        f.word_len = WLEN_16;
      end
      8'h01: begin
        f.just = JUST_RIGHT;
        f.word_len = WLEN_20;
      end
      8'h02: begin
        f.just = JUST_RIGHT;
        f.word_len = WLEN_24;
      end
      8'h03: begin
        f.just = JUST_I2S;
        f.word_len = WLEN_16;
      end
      8'h04: begin
        f.just = JUST_I2S;
        f.word_len = WLEN_20;
      end
      8'h05: begin
        f.just = JUST_I2S;
        f.word_len = WLEN_24;
      end
      8'h06: begin
        f.just = JUST_LEFT;
        f.word_len = WLEN_16;
      end
      8'h07: begin
        f.just = JUST_LEFT;
        f.word_len = WLEN_20;
      end
      8'h08: begin
        f.just = JUST_LEFT;
        f.word_len = WLEN_24;
      end
      8'h0a: begin
        f.just = JUST_RIGHT;
        f.word_len = WLEN_18;
      end
      8'h13: begin
        f.just = JUST_I2S;
        f.word_len = WLEN_16;
        f.sclk32 = 1'b1;
      end
      8'h16: begin
        f.just = JUST_LEFT;
        f.word_len = WLEN_16;
        f.sclk32 = 1'b1;
      end
      default: begin
        f.valid = 1'b0;
      end
    endcase
    return f;
  endfunction

  // De-emphasis selection
  function automatic acfc_deemph_e deemph_of(input logic [1:0] code);
    acfc_deemph_e d;
    d = DEEMPH_NONE;
    case (code)
      2'h0: d = DEEMPH_NONE;
      2'h1: d = DEEMPH_RSVD;
      2'h2: d = DEEMPH_44K1;
      2'h3: d = DEEMPH_48K;
      default: d = DEEMPH_NONE;
    endcase
    return d;
  endfunction

  // Autodetect runs unless the disable bit is set
  assign auto_mode = ~st_reg.sysopt[SYS_AUTODIS_BIT];

  // Clock setup view: detected values replace bits 7:2 in autodetect
  always_comb begin
    clock_view = st_reg.clock_setup;
    if (auto_mode) begin
      clock_view[7:CLK_RATE_LSB] = DET_RATE;
      clock_view[CLK_RATE_LSB-1:CLK_MCLK_LSB] = DET_MCLK;
    end
  end

  // Fault flag placement in the status byte
  always_comb begin
    fault_view = 8'h00;
    fault_view[FLT_PLL_BIT] = flt_flags[3];
    fault_view[FLT_SCLK_BIT] = flt_flags[2];
    fault_view[FLT_LRCLK_BIT] = flt_flags[1];
    fault_view[FLT_SLIP_BIT] = flt_flags[0];
  end

  // Fault events and software clear for the sticky bank
  assign flt_set = {DET_ERR.pll_lock, DET_ERR.sclk,
                    DET_ERR.lrclk, DET_ERR.slip};
  assign flt_clr_we = REG_REQ.wr && (REG_REQ.addr == ADDR_FAULT);
  assign flt_keep = {REG_REQ.wdata[FLT_PLL_BIT],
                     REG_REQ.wdata[FLT_SCLK_BIT],
                     REG_REQ.wdata[FLT_LRCLK_BIT],
                     REG_REQ.wdata[FLT_SLIP_BIT]};

  acfc_sticky #(
    .N(FLT_COUNT)
  ) u_faults (
    .CLK(CLK),
    .RST_N(RST_N),
    .SET(flt_set),
    .CLR_WE(flt_clr_we),
    .CLR_KEEP(flt_keep),
    .FLAGS(flt_flags)
  );

  // Register writes, read-back and configuration decode
  always_comb begin
    logic [2:0] rate;
    logic [2:0] mcode;
    logic [9:0] mmul;
    acfc_fmt_s fmt;
    rate = '0;
    mcode = '0;
    mmul = '0;
    fmt = '0;
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    // Writes to writable registers
    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        ADDR_CLOCK_SETUP: st_next.clock_setup = REG_REQ.wdata;
        ADDR_SYSOPT: begin
          st_next.sysopt = REG_REQ.wdata & SYS_WR_MASK;
        end
        ADDR_FORMAT: st_next.format = REG_REQ.wdata;
        default: st_next.rvalid = 1'b0;
      endcase
    end
    // Reads return old contents, unmapped reads zero
    if (REG_REQ.rd) begin
      st_next.rvalid = 1'b1;
      case (REG_REQ.addr)
        ADDR_CLOCK_SETUP: st_next.rdata = clock_view;
        ADDR_IDENT: st_next.rdata = {1'b0, ID_CODE};
        ADDR_FAULT: st_next.rdata = fault_view;
        ADDR_SYSOPT: st_next.rdata = st_reg.sysopt;
        ADDR_FORMAT: st_next.rdata = st_reg.format;
        default: st_next.rdata = 8'h00;
      endcase
    end
    // Effective clocking from detector or from the host
    rate = clock_view[7:CLK_RATE_LSB];
    mcode = clock_view[CLK_RATE_LSB-1:CLK_MCLK_LSB];
    mmul = mclk_mult_of(mcode);
    fmt = fmt_of(st_reg.format);
    st_next.cfg.rate_code = rate;
    st_next.cfg.mclk_mult = mmul;
    st_next.cfg.mclk_rsvd = (mmul == 10'h000);
    // Bit clock multiple
    if (st_reg.clock_setup[CLK_SCLK48_BIT]) begin
      st_next.cfg.sclk_mult = SCLK_X48;
    end else if (fmt.sclk32) begin
      st_next.cfg.sclk_mult = SCLK_X32;
    end else begin
      st_next.cfg.sclk_mult = SCLK_X64;
    end
    // Valid flag only counts in manual mode
    st_next.cfg.clk_valid = ~auto_mode &&
                            st_reg.clock_setup[CLK_VALID_BIT];
    // System options
    st_next.cfg.dc_block_en = st_reg.sysopt[SYS_DCBLK_BIT];
    st_next.cfg.hard_unmute = st_reg.sysopt[SYS_HARDUNM_BIT];
    st_next.cfg.autodetect_en = auto_mode;
    st_next.cfg.soft_start_en = ~st_reg.sysopt[SYS_SSDIS_BIT];
    st_next.cfg.deemph =
      deemph_of(st_reg.sysopt[SYS_DEEMPH_LSB+1:SYS_DEEMPH_LSB]);
    // Serial format
    st_next.cfg.just = fmt.just;
    st_next.cfg.word_len = fmt.word_len;
    st_next.cfg.fmt_valid = fmt.valid;
    // Flag combinations the host must not choose
    st_next.cfg.combo_bad =
      (((mmul == MCLK_X384) || (mmul == MCLK_X512)) &&
       (rate >= RATE_176K4)) ||
      (st_reg.clock_setup[CLK_SCLK48_BIT] &&
       (mmul != MCLK_X192) && (mmul != MCLK_X384));
  end

  // State register with documented defaults
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg.clock_setup <= RST_CLOCK_SETUP;
      st_reg.sysopt <= RST_SYSOPT;
      st_reg.format <= RST_FORMAT;
      st_reg.rdata <= 8'h00;
      st_reg.rvalid <= 1'b0;
      st_reg.cfg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA = st_reg.rdata;
  assign REG_RVALID = st_reg.rvalid;
  assign CFG_OUT = st_reg.cfg;

endmodule // acfc_regs
`default_nettype wire

// File: rtl/acfc_sticky.sv
// Bank of sticky fault flags, set by hardware, cleared by written zeros.
// Assumes set pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module acfc_sticky #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Hardware events
  input wire logic [N-1:0] SET,
  // Software clear
  input wire logic CLR_WE,
  input wire logic [N-1:0] CLR_KEEP,
  // Flag state
  output logic [N-1:0] FLAGS
);

  typedef struct packed {
    logic [N-1:0] flags;
  } acfc_stk_s;

  acfc_stk_s st_reg;
  acfc_stk_s st_next;

  // Refuse an empty bank
  if (N < 1) begin : g_chk
    $error("acfc_sticky needs at least one flag");
  end

  // Zero written clears, one written keeps, event always wins
  always_comb begin
    st_next = st_reg;
    if (CLR_WE) begin
      st_next.flags = st_reg.flags & CLR_KEEP;
    end
    st_next.flags = st_next.flags | SET;
  end

  // State register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign FLAGS = st_reg.flags;

endmodule // acfc_sticky
`default_nettype wire

// File: tb/acfc_det_model.sv
// Stand-in for the audio-side clock detector: levels and fault events.
// Assumes the bench calls its tasks; changes land just after an edge.
`timescale 1ns/1ps
`default_nettype none
module acfc_det_model (
  // Clock
  input wire logic CLK,
  // Detector outputs
  output var logic [2:0] RATE,
  output var logic [2:0] MCLK,
  output var acfc_pkg::acfc_err_s ERR
);
  import acfc_pkg::*;
  // Start at 48 kHz and 256x, no faults
  initial begin
    RATE = 3'h3;
    MCLK = 3'h3;
    ERR = '0;
  end
  // One-cycle fault event
  task automatic pulse(input logic [3:0] bits);
    @(posedge CLK);
    ERR <= bits;
    @(posedge CLK);
    ERR <= '0;
  endtask
  // New detected rate and ratio
  task automatic found(input logic [2:0] r, input logic [2:0] m);
    @(posedge CLK);
    RATE <= r;
    MCLK <= m;
  endtask
endmodule // acfc_det_model
`default_nettype wire

// File: tb/acfc_regs_monitor.sv
// Checker for the clock and format registers, bound to acfc_regs.
// Assumes one clock, one-cycle read answer and one-cycle config lag.
`timescale 1ns/1ps
`default_nettype none
module acfc_regs_monitor #(
  parameter logic [6:0] ID_CODE = 7'h11
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire acfc_pkg::acfc_req_s REG_REQ,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  // Detector and config
  input wire logic [2:0] DET_RATE,
  input wire logic [2:0] DET_MCLK,
  input wire acfc_pkg::acfc_err_s DET_ERR,
  input wire acfc_pkg::acfc_cfg_s CFG_OUT
);
  import acfc_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Read answers and reserved bits
  a_ident_read: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_IDENT
    |=> REG_RVALID && REG_RDATA == {1'b0, ID_CODE})
    else $error("identification read wrong");
  a_fault_sticky: assert property (
    DET_ERR.slip ##1 !(REG_REQ.wr && REG_REQ.addr == ADDR_FAULT)
    ##1 REG_REQ.rd && REG_REQ.addr == ADDR_FAULT
    |=> REG_RDATA[FLT_SLIP_BIT] && REG_RDATA[2:0] == 3'h0)
    else $error("slip flag lost");
  a_opt_rsvd: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_SYSOPT
    |=> REG_RDATA[6] == 1'b0 && REG_RDATA[4] == 1'b0)
    else $error("reserved option bit set");
  // Decoded configuration
  a_mclk_rsvd: assert property (
    $past(RST_N) |-> CFG_OUT.mclk_rsvd == (CFG_OUT.mclk_mult == 10'h000))
    else $error("reserved ratio decode wrong");
  a_valid_manual: assert property (
    CFG_OUT.clk_valid |-> !CFG_OUT.autodetect_en)
    else $error("clock valid in autodetect");
  a_sclk_48x: assert property (
    REG_REQ.wr && REG_REQ.addr == ADDR_CLOCK_SETUP && REG_REQ.wdata[1]
    ##1 !(REG_REQ.wr && REG_REQ.addr == ADDR_CLOCK_SETUP)
    |=> CFG_OUT.sclk_mult == SCLK_X48)
    else $error("bit clock not 48x");
  a_autodet_off: assert property (
    REG_REQ.wr && REG_REQ.addr == ADDR_SYSOPT && REG_REQ.wdata[3]
    ##1 !(REG_REQ.wr && REG_REQ.addr == ADDR_SYSOPT)
    |=> !CFG_OUT.autodetect_en)
    else $error("autodetect still on");
  a_det_rate: assert property (
    CFG_OUT.autodetect_en |-> CFG_OUT.rate_code == $past(DET_RATE))
    else $error("detected rate not used");
endmodule // acfc_regs_monitor
bind acfc_regs acfc_regs_monitor #(.ID_CODE(ID_CODE)) i_mon (.CLK(CLK),
  .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .DET_RATE(DET_RATE), .DET_MCLK(DET_MCLK),
  .DET_ERR(DET_ERR), .CFG_OUT(CFG_OUT));
`default_nettype wire

// File: tb/acfc_regs_test.sv
// Self-checking bench for the clock and format registers.
// Assumes one-cycle read answer and config two edges after a write.
`timescale 1ns/1ps
`default_nettype none
module acfc_regs_test;
  import acfc_pkg::*;
  localparam logic [6:0] ID = 7'h11; // Arbitrary value
  logic clk;
  logic rst_n;
  acfc_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic [2:0] det_rate;
  logic [2:0] det_mclk;
  acfc_err_s det_err;
  acfc_cfg_s cfg;
  int n_fail = 0;
  int n_tests = 0;
  logic [7:0] e;
  logic [7:0] fc [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h0a, 8'h13, 8'h16, 8'h09, 8'h20};
  int fj [12] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 0, 1, 2};
  int fw [11] = '{16, 20, 24, 16, 20, 24, 16, 20, 24, 18, 16};
  logic [2:0] mc [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
  logic [9:0] mm [4] = '{MCLK_X256, MCLK_X384, MCLK_X512, 10'h000};
  acfc_regs #(.ID_CODE(ID)) i_dut (.CLK(clk), .RST_N(rst_n), .REG_REQ(req),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .DET_RATE(det_rate),
    .DET_MCLK(det_mclk), .DET_ERR(det_err), .CFG_OUT(cfg));
  acfc_det_model i_det (.CLK(clk), .RATE(det_rate), .MCLK(det_mclk),
    .ERR(det_err));
  // Compare and count
  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] x);
    n_tests++;
    if (s !== x) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Register port accesses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    chk("rvalid", 10'(rvalid), 10'h001);
    chk($sformatf("reg %h", a), 10'(rdata), 10'(x));
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  // Verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  // Test sequence
  initial begin
    rst_n = 1'b0;
    req = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CLOCK_SETUP, {3'h3, 3'h3, 2'b00});
    rd(ADDR_IDENT, {1'b0, ID});
    rd(ADDR_FAULT, 8'h00);
    rd(ADDR_SYSOPT, 8'ha0);
    rd(ADDR_FORMAT, 8'h05);
    rd(8'h07, 8'h00);
    i_det.found(3'h7, 3'h2);
    rd(ADDR_CLOCK_SETUP, {3'h7, 3'h2, 2'b00});
    $display("test defaults done");
    e = 8'h00;
    for (int i = 0; i < 4; i++) begin
      i_det.pulse(4'(1 << i));
      e = e | 8'(8 << i);
      rd(ADDR_FAULT, e);
    end
    wr(ADDR_FAULT, 8'h40);
    rd(ADDR_FAULT, 8'h40);
    // Same-cycle slip and clear-all: slip survives, others drop
    fork
      i_det.pulse(4'h1);
      wr(ADDR_FAULT, 8'h00);
    join
    rd(ADDR_FAULT, 8'h08);
    wr(ADDR_FAULT, 8'h00);
    rd(ADDR_FAULT, 8'h00);
    $display("test faults done");
    wr(ADDR_SYSOPT, 8'hff);
    rd(ADDR_SYSOPT, 8'haf);
    chk("autodet", 10'(cfg.autodetect_en), 10'h000);
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_SYSOPT, 8'h08 | 8'(d));
      settle();
      chk("deemph", 10'(cfg.deemph), 10'(d));
      chk("dcblk", 10'(cfg.dc_block_en), 10'h000);
      chk("hardunm", 10'(cfg.hard_unmute), 10'h000);
      chk("sstart", 10'(cfg.soft_start_en), 10'h001);
    end
    $display("test options done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CLOCK_SETUP, {3'h3, mc[i], 2'b01});
      settle();
      chk("mclk", cfg.mclk_mult, mm[i]);
      chk("rsvd", 10'(cfg.mclk_rsvd), 10'(i == 3));
      chk("combo", 10'(cfg.combo_bad), 10'h000);
      chk("valid", 10'(cfg.clk_valid), 10'h001);
    end
    // Host misuse is flagged: 384x at 192 kHz, 48x with 256x master
    wr(ADDR_CLOCK_SETUP, {3'h7, 3'h5, 2'b01});
    settle();
    chk("combo", 10'(cfg.combo_bad), 10'h001);
    wr(ADDR_CLOCK_SETUP, {3'h3, 3'h3, 2'b11});
    settle();
    chk("combo", 10'(cfg.combo_bad), 10'h001);
    wr(ADDR_CLOCK_SETUP, {3'h5, 3'h5, 2'b11});
    rd(ADDR_CLOCK_SETUP, 8'hb7);
    chk("sclk", 10'(cfg.sclk_mult), 10'(SCLK_X48));
    chk("combo", 10'(cfg.combo_bad), 10'h000);
    chk("rate", 10'(cfg.rate_code), 10'h005);
    wr(ADDR_CLOCK_SETUP, {3'h3, 3'h3, 2'b00});
    settle();
    chk("valid", 10'(cfg.clk_valid), 10'h000);
    $display("test clocks done");
    for (int i = 0; i < 14; i++) begin
      wr(ADDR_FORMAT, fc[i]);
      settle();
      chk("fmtok", 10'(cfg.fmt_valid),
        10'(i < 12));
      if (i < 12) begin
        chk("just", 10'(cfg.just), 10'(fj[i]));
        chk("sclk", 10'(cfg.sclk_mult),
          10'(fc[i][4] ? SCLK_X32 : SCLK_X64));
      end
      if (i < 11)
        chk("wlen", 10'(cfg.word_len), 10'(fw[i]));
    end
    $display("test formats done");
    end_sim();
  end
endmodule // acfc_regs_test
`default_nettype wire
